// ==== analog_reference_io_conditioning.sv ====
// analog input conditioning, signal loss, analog output and relay select
// assumes synchronous inputs, one clock and a plain register port
`include "aref_cond_defines.svh"

module analog_reference_io_conditioning
  import aref_cond_pkg::*;
#(
  parameter int unsigned UPD_VHZ_CYC   = `UPD_VHZ_CYC,
  parameter int unsigned UPD_VEC_CYC   = `UPD_VEC_CYC,
  parameter int unsigned START_DLY_CYC = `START_DLY_CYC,
  parameter int unsigned SNAP_CYC      = `SNAP_CYC,
  parameter int unsigned HIST_DEPTH    = `HIST_DEPTH
) (
  input  wire logic               ref_clk_i,
  input  wire logic               resetn_i,
  input  wire logic               ce_i,
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [31:0]        reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [31:0]        reg_rdata_o,
  input  wire logic [11:0]        adc_i,
  input  wire term_in_t           term_i,
  input  wire drive_fb_t          fb_i,
  input  wire logic               fault_any_i,
  input  wire logic               alarm_any_i,
  input  wire logic               net_active_i,
  input  wire logic               permissive_i,
  output logic signed [15:0]      ref_o,
  output logic                    motor_volt_en_o,
  output logic [11:0]             aout_o,
  output logic                    relay_o,
  output logic                    loss_fault_o,
  output logic                    loss_alarm_o
);

  // ========================================================================
  // elaboration checks
  localparam int unsigned UPD_MAX = (UPD_VHZ_CYC > UPD_VEC_CYC) ?
                                    UPD_VHZ_CYC : UPD_VEC_CYC;
  localparam int UPD_W  = $clog2(UPD_MAX + 1);
  localparam int DLY_W  = $clog2(START_DLY_CYC + 1);
  localparam int SNAP_W = $clog2(SNAP_CYC + 1);
  localparam int HP_W   = (HIST_DEPTH > 1) ? $clog2(HIST_DEPTH) : 1;

  if (UPD_VHZ_CYC < 1 || UPD_VEC_CYC < 1 || START_DLY_CYC < 1 ||
      SNAP_CYC < 1 || HIST_DEPTH < 2) begin : g_bad_param
    $error("timing counts must be at least 1 and history depth 2");
  end

  // ========================================================================
  // software registers
  ctrl_t              ctrl_r;       // configuration word
  logic signed [15:0] offset_r;     // input offset, converter counts
  logic [15:0]        gain_r;       // gain, 8.8 fixed point
  logic signed [15:0] preset_r;     // first preset speed
  logic signed [15:0] start_thr_r;  // analog start level
  logic signed [15:0] stop_thr_r;   // analog stop level
  logic [31:0]        rdata_r;      // read data, valid one cycle

  // write decode
  wire wr_ctrl_w   = ce_i && reg_wr_i && (reg_addr_i == `REG_CTRL);
  wire wr_off_w    = ce_i && reg_wr_i && (reg_addr_i == `REG_OFFSET);
  wire wr_gain_w   = ce_i && reg_wr_i && (reg_addr_i == `REG_GAIN);
  wire wr_pre_w    = ce_i && reg_wr_i && (reg_addr_i == `REG_PRESET);
  wire wr_sthr_w   = ce_i && reg_wr_i && (reg_addr_i == `REG_START_THR);
  wire wr_pthr_w   = ce_i && reg_wr_i && (reg_addr_i == `REG_STOP_THR);
  wire wr_stat_w   = ce_i && reg_wr_i && (reg_addr_i == `REG_STATUS);

  // unsupported codes are refused so the block never runs undefined modes
  wire [3:0] wr_ain_w   = reg_wdata_i[`CTRL_AIN_LSB +: 4];
  wire [2:0] wr_relay_w = reg_wdata_i[`CTRL_RELAY_LSB +: 3];
  ctrl_t     ctrl_nxt;
  assign ctrl_nxt = '{
    remote_terminal_source: reg_wdata_i[`CTRL_REMOTE_BIT],
    vector_mode:            reg_wdata_i[`CTRL_VECTOR_BIT],
    relay_cfg:  (wr_relay_w > `RELAY_CFG_MAX) ? ctrl_r.relay_cfg
                                               : wr_relay_w,
    aout_src:   reg_wdata_i[`CTRL_AOUT_LSB +: 2],
    ain_cfg:    (wr_ain_w > `AIN_CFG_MAX) ? ctrl_r.ain_cfg : wr_ain_w
  };

  // configuration registers
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r      <= '{1'b0, 1'b0, `RST_RELAY_CFG, `RST_AOUT_SRC,
                       `RST_AIN_CFG};
      offset_r    <= 16'sh0000;
      gain_r      <= `RST_GAIN;
      preset_r    <= 16'sh0000;
      start_thr_r <= `RST_START_THR;
      stop_thr_r  <= `RST_STOP_THR;
    end else begin
      if (wr_ctrl_w) ctrl_r      <= ctrl_nxt;
      if (wr_off_w)  offset_r    <= reg_wdata_i[15:0];
      if (wr_gain_w) gain_r      <= reg_wdata_i[15:0];
      if (wr_pre_w)  preset_r    <= reg_wdata_i[15:0];
      if (wr_sthr_w) start_thr_r <= reg_wdata_i[15:0];
      if (wr_pthr_w) stop_thr_r  <= reg_wdata_i[15:0];
    end
  end

  // ========================================================================
  // input configuration decode
  wire [3:0] cfg_w      = ctrl_r.ain_cfg;
  wire ain_bip_w        = (cfg_w == 4'h0) || (cfg_w == 4'h1);
  wire ain_curr_w       = (cfg_w == 4'h4) || (cfg_w == 4'h5) ||
                          ((cfg_w >= 4'h8) && (cfg_w <= 4'hB));
  wire ain_fault_cfg_w  = (cfg_w == 4'h4) || (cfg_w == 4'h5);
  wire ain_alarm_cfg_w  = (cfg_w >= 4'h8) && (cfg_w <= 4'hB);
  wire ain_hold_cfg_w   = (cfg_w == 4'h8) || (cfg_w == 4'h9);
  wire ain_preset_cfg_w = (cfg_w == 4'hA) || (cfg_w == 4'hB);
  // every inverted selection is odd, and 12 is even
  wire ain_inv_w        = cfg_w[0];

  // ========================================================================
  // scaling path: shift, offset, clamp, gain, saturate, negate
  wire [17:0] ain_shift_w = ain_curr_w ? 18'(`AIN_4MA_CODE) :
                            ain_bip_w  ? 18'(`AIN_BIP_MID)  : 18'h00000;
  wire signed [17:0] ain_base_w = $signed({6'h00, adc_i}) -
                                  $signed(ain_shift_w);
  wire signed [17:0] ain_sum_w  = ain_base_w +
                                  {{2{offset_r[15]}}, offset_r};
  // bipolar inputs keep their sign; all others stop at zero
  wire signed [17:0] ain_clamp_w = (!ain_bip_w && ain_sum_w < 0) ?
                                   18'sh00000 : ain_sum_w;
  wire signed [34:0] ain_prod_w  = ain_clamp_w * $signed({1'b0, gain_r});
  wire signed [26:0] ain_scal_w  = ain_prod_w[34:8];
  // symmetric limit so that the negation below can never wrap
  wire signed [15:0] ain_sat_w =
    (ain_scal_w >  27'sd32767) ? 16'(`REF_LIMIT) :
    (ain_scal_w < -27'sd32767) ? -16'(`REF_LIMIT) :
    ain_scal_w[15:0];
  wire signed [15:0] cond_w = ain_inv_w ? -ain_sat_w : ain_sat_w;

  // ========================================================================
  // signal loss detection with 2 mA trip and 4 mA return
  logic loss_fault_r;  // sticky, cleared by writing one
  logic loss_alarm_r;  // clears itself when the loop recovers
  wire  loss_now_w = ain_curr_w && (adc_i < 12'(`AIN_2MA_CODE));
  wire  back_w     = adc_i >= 12'(`AIN_4MA_CODE);
  wire  fault_clr_w = wr_stat_w && reg_wdata_i[`STAT_FAULT_BIT];

  // a loss in the same cycle as the clear keeps the fault set
  wire fault_nxt = (ain_fault_cfg_w && loss_now_w) ||
                   (loss_fault_r && !fault_clr_w);
  wire alarm_nxt = ain_alarm_cfg_w &&
                   ((ain_alarm_cfg_w && loss_now_w) ||
                    (loss_alarm_r && !back_w));

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      loss_fault_r <= 1'b0;
      loss_alarm_r <= 1'b0;
    end else if (ce_i) begin
      loss_fault_r <= fault_nxt;
      loss_alarm_r <= alarm_nxt;
    end
  end

  // ========================================================================
  // reference history: one snapshot a second, oldest is 4 to 5 s old
  logic [SNAP_W-1:0]  snap_cnt_r;
  logic [HP_W-1:0]    hist_wp_r;
  logic signed [15:0] hist_r [HIST_DEPTH];
  wire snap_tick_w = (snap_cnt_r >= SNAP_W'(SNAP_CYC - 1));
  // snapshots stop during a loss so the held value does not age out
  wire snap_we_w   = ce_i && snap_tick_w && !loss_alarm_r;

  // snapshot timer and write pointer
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      snap_cnt_r <= '0;
      hist_wp_r  <= '0;
    end else if (ce_i) begin
      snap_cnt_r <= snap_tick_w ? '0 : snap_cnt_r + 1'b1;
      if (snap_we_w) begin
        hist_wp_r <= (hist_wp_r == HP_W'(HIST_DEPTH - 1)) ?
                     '0 : hist_wp_r + 1'b1;
      end
    end
  end

  // one storage word per history entry
  for (genvar i = 0; i < HIST_DEPTH; i++) begin : g_hist
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        hist_r[i] <= 16'sh0000;
      end else if (snap_we_w && hist_wp_r == HP_W'(i)) begin
        hist_r[i] <= cond_w;
      end
    end
  end

  // the slot about to be overwritten holds the oldest snapshot
  wire signed [15:0] hist_old_w = hist_r[hist_wp_r];

  // ========================================================================
  // reference selection
  logic signed [15:0] ref_r;
  wire signed [15:0] ref_nxt =
    (loss_alarm_r && ain_hold_cfg_w)   ? hist_old_w :
    (loss_alarm_r && ain_preset_cfg_w) ? preset_r   :
    cond_w;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) ref_r <= 16'sh0000;
    else if (ce_i) ref_r <= ref_nxt;
  end

  // ========================================================================
  // analog start/stop, threshold hysteresis between the two levels
  arun_state_t arun_r;
  arun_state_t arun_nxt;
  wire ana_mode_w = (cfg_w == 4'hC) && ctrl_r.remote_terminal_source;

  // decides run from the scaled level; the temperature drift of the
  // input can keep it above the stop level, hence the contact gating
  always_comb begin
    arun_nxt = arun_r;
    case (arun_r)
      ARUN_STOP: if (cond_w >= start_thr_r) arun_nxt = ARUN_RUN;
      ARUN_RUN:  if (cond_w <= stop_thr_r)  arun_nxt = ARUN_STOP;
      default:   arun_nxt = ARUN_STOP;
    endcase
    if (!ana_mode_w) arun_nxt = ARUN_STOP;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) arun_r <= ARUN_STOP;
    else if (ce_i) arun_r <= arun_nxt;
  end

  // stop and function loss act in every mode
  wire contacts_ok_w = term_i.func_loss_closed && term_i.stop_closed;
  wire run_req_w = contacts_ok_w && term_i.start_closed &&
                   (!ana_mode_w || arun_r == ARUN_RUN);

  // ========================================================================
  // start delay before motor voltage
  start_state_t      st_r;
  start_state_t      st_nxt;
  logic [DLY_W-1:0]  dly_cnt_r;
  wire dly_done_w = (dly_cnt_r >= DLY_W'(START_DLY_CYC - 1));

  // the delay holds off voltage; relay choice 1 then closes one cycle after it appears
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      DLY_IDLE: begin
        if (run_req_w) begin
          st_nxt = (ctrl_r.relay_cfg == 3'h1) ? DLY_WAIT : DLY_ON;
        end
      end
      DLY_WAIT: begin
        if (!run_req_w) st_nxt = DLY_IDLE;
        else if (dly_done_w) st_nxt = DLY_ON;
      end
      DLY_ON:  if (!run_req_w) st_nxt = DLY_IDLE;
      default: st_nxt = DLY_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r      <= DLY_IDLE;
      dly_cnt_r <= '0;
    end else if (ce_i) begin
      st_r      <= st_nxt;
      dly_cnt_r <= (st_r == DLY_WAIT) ? dly_cnt_r + 1'b1 : '0;
    end
  end

  wire volt_w = (st_r == DLY_ON);

  // ========================================================================
  // relay indication
  logic relay_r;
  wire  fault_all_w = fault_any_i || loss_fault_r;
  wire  alarm_all_w = alarm_any_i || loss_alarm_r;
  logic relay_nxt;

  always_comb begin
    case (ctrl_r.relay_cfg)
      3'h0:    relay_nxt = fault_all_w;
      3'h1:    relay_nxt = volt_w;
      3'h2:    relay_nxt = volt_w;
      3'h3:    relay_nxt = net_active_i;
      3'h4:    relay_nxt = permissive_i;
      3'h5:    relay_nxt = alarm_all_w;
      3'h6:    relay_nxt = !fault_all_w;
      default: relay_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) relay_r <= 1'b0;
    else if (ce_i) relay_r <= relay_nxt;
  end

  // ========================================================================
  // analog output source, scaling and refresh
  logic [UPD_W-1:0] upd_cnt_r;
  logic [11:0]      aout_r;
  wire [UPD_W-1:0]  upd_lim_w = ctrl_r.vector_mode ?
                                UPD_W'(UPD_VEC_CYC - 1) :
                                UPD_W'(UPD_VHZ_CYC - 1);
  wire upd_tick_w = (upd_cnt_r >= upd_lim_w);

  wire signed [15:0] aout_sig_w =
    (ctrl_r.aout_src[0] == 1'b0) ? fb_i.speed :
    (ctrl_r.aout_src[1] == 1'b0) ? fb_i.torque :
    ctrl_r.vector_mode ? fb_i.torque : fb_i.current;
  // adding half scale to a two's complement word flips its top bit
  wire [11:0] aout_bip_w = {~aout_sig_w[15], aout_sig_w[14:4]};
  wire [15:0] aout_mag_w = aout_sig_w[15] ? 16'(-aout_sig_w) :
                           aout_sig_w;
  // magnitude of the full negative code would reach one step past full
  wire [11:0] aout_uni_w = (aout_mag_w[15:3] > 13'(`AOUT_FULL)) ?
                           12'(`AOUT_FULL) : aout_mag_w[14:3];
  wire [11:0] aout_nxt = ctrl_r.aout_src[1] ? aout_uni_w : aout_bip_w;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      upd_cnt_r <= '0;
      aout_r    <= 12'h800;
    end else if (ce_i) begin
      upd_cnt_r <= upd_tick_w ? '0 : upd_cnt_r + 1'b1;
      if (upd_tick_w) aout_r <= aout_nxt;
    end
  end

  // ========================================================================
  // register read, data stands in the cycle after the strobe only
  wire [31:0] stat_w = {27'h0000000, arun_r == ARUN_RUN, volt_w,
                        relay_r, loss_alarm_r, loss_fault_r};
  wire [31:0] rd_mux_w =
    (reg_addr_i == `REG_CTRL)      ? {21'h000000, ctrl_r}          :
    (reg_addr_i == `REG_OFFSET)    ? {16'h0000, offset_r}          :
    (reg_addr_i == `REG_GAIN)      ? {16'h0000, gain_r}            :
    (reg_addr_i == `REG_PRESET)    ? {16'h0000, preset_r}          :
    (reg_addr_i == `REG_START_THR) ? {16'h0000, start_thr_r}       :
    (reg_addr_i == `REG_STOP_THR)  ? {16'h0000, stop_thr_r}        :
    (reg_addr_i == `REG_STATUS)    ? stat_w                        :
    (reg_addr_i == `REG_REF)       ? {16'h0000, ref_r}             :
    32'h00000000;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) rdata_r <= 32'h00000000;
    else if (ce_i) rdata_r <= reg_rd_i ? rd_mux_w : 32'h00000000;
  end

  // ========================================================================
  // outputs
  assign reg_rdata_o     = rdata_r;
  assign ref_o           = ref_r;
  assign motor_volt_en_o = volt_w;
  assign aout_o          = aout_r;
  assign relay_o         = relay_r;
  assign loss_fault_o    = loss_fault_r;
  assign loss_alarm_o    = loss_alarm_r;

  // ========================================================================
  // assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_clamp_nonneg: assert property (
    ce_i && (cfg_w == 4'h2) && !wr_ctrl_w |=> ref_o >= 0)
    else $error("scaled 0-10 V reference went negative");
  a_neg_cfg3: assert property (
    ce_i && (cfg_w == 4'h3) && !wr_ctrl_w |=> ref_o <= 0)
    else $error("inverted reference went positive");
  a_loss_fault: assert property (
    ce_i && ain_fault_cfg_w && adc_i < 12'(`AIN_2MA_CODE)
    |=> loss_fault_o [*2])
    else $error("signal loss fault not raised and held");
  a_alarm_clear: assert property (
    ce_i && loss_alarm_o && adc_i >= 12'(`AIN_4MA_CODE) |=> !loss_alarm_o)
    else $error("loss alarm did not clear on return");
  a_preset_sub: assert property (
    ce_i && loss_alarm_o && ain_preset_cfg_w && !wr_pre_w
    |=> ref_o == $past(preset_r))
    else $error("preset speed not substituted");
  a_stop_wins: assert property (
    ce_i && !contacts_ok_w |=> !motor_volt_en_o)
    else $error("motor voltage kept after stop contact opened");
  a_start_delay: assert property (
    $rose(motor_volt_en_o) && ctrl_r.relay_cfg == 3'h1
    |-> $past(st_r) == DLY_WAIT && $past(dly_done_w))
    else $error("motor voltage without start delay");
  a_aout_hold: assert property (
    !$stable(aout_o) |-> $past(upd_tick_w) && $past(ce_i))
    else $error("analog output changed outside refresh");
  a_relay_nofault: assert property (
    ce_i && ctrl_r.relay_cfg == 3'h6 |=> relay_o == !$past(fault_all_w))
    else $error("relay does not show absence of fault");

  c_alarm_hold: cover property (
    loss_alarm_o && ain_hold_cfg_w ##1 !loss_alarm_o);
  c_delay_start: cover property (st_r == DLY_WAIT ##1 st_r == DLY_ON);
  c_analog_run: cover property (ana_mode_w && arun_r == ARUN_RUN);
  c_aout_refresh: cover property (upd_tick_w && ctrl_r.aout_src[1]);

endmodule  // analog_reference_io_conditioning

// ==== analog_reference_io_conditioning_bench.sv ====
// self-checking bench for the analog reference conditioning block
// assumes the far-side model and shortened timing parameters
`include "aref_cond_defines.svh"
module analog_reference_io_conditioning_bench import aref_cond_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, run = 0, ce = 1;
  logic fault = 0, alarm = 0, net = 0, perm = 0, volt, relay, lf, la;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rv;
  logic [11:0] code = 12'h000, adc, aout;
  logic signed [15:0] ref_v;
  drive_fb_t fb = '0;
  term_in_t  term;
  int fail_count = 0, n_checks = 0, cyc = 0;
  int cfgs[6] = '{2, 3, 6, 7, 4, 5};
  // ====
  aref_far_side far (.ref_clk_i(clk), .code_i(code), .run_i(run),
    .adc_o(adc), .term_o(term));
  analog_reference_io_conditioning #(.UPD_VHZ_CYC(50), .UPD_VEC_CYC(10),
    .START_DLY_CYC(20), .SNAP_CYC(16), .HIST_DEPTH(2)) dut (
    .ref_clk_i(clk), .resetn_i(rstn), .ce_i(ce), .reg_addr_i(addr),
    .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .adc_i(adc), .term_i(term), .fb_i(fb), .fault_any_i(fault),
    .alarm_any_i(alarm), .net_active_i(net), .permissive_i(perm),
    .ref_o(ref_v), .motor_volt_en_o(volt), .aout_o(aout), .relay_o(relay),
    .loss_fault_o(lf), .loss_alarm_o(la));
  // ====
  initial forever #12.5 clk = ~clk;
  // hang guard: far beyond the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rreg(logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rv = rdat;
  endtask
  function automatic logic [31:0] cw(int a, int s, int r);
    return 32'(a) | (32'(s) << 4) | (32'(r) << 6);
  endfunction
  task automatic pause(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ====
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    pause(1);
    chk("aout", 16'h0800, 16'(aout));
    rreg(`REG_CTRL);
    chk("ctrl", 16'h0002, rv[15:0]);
    // a write while the clock enable is low must be lost
    @(posedge clk);
    ce <= 1'b0;
    wreg(`REG_PRESET, 32'h0055);
    ce <= 1'b1;
    rreg(`REG_PRESET);
    chk("frozen", 16'h0000, rv[15:0]);
    $display("reset test done");
    // relay choices 3 to 6, first with net and permissive high, then with alarm and fault high
    for (int p = 0; p < 2; p++) begin
      for (int c = 3; c < 7; c++) begin
        wreg(`REG_CTRL, cw(2, 0, c));
        {net, perm, alarm, fault} <= p ? 4'b0011 : 4'b1100;
        pause(3);
        chk("relay", 16'((c == 5) ^ (p == 0)), 16'(relay));
      end
    end
    @(posedge clk);
    {net, perm, alarm, fault} <= 4'b0000;
    $display("relay test done");
    wreg(`REG_OFFSET, 32'h10);
    wreg(`REG_GAIN, 32'h200);
    code <= 12'd1000;
    foreach (cfgs[i]) begin
      wreg(`REG_CTRL, cw(cfgs[i], 0, 0));
      pause(4);
      rv = cfgs[i] inside {4, 5} ? 394 : 2032;
      rv[15:0] = cfgs[i] % 2 ? -rv[15:0] : rv[15:0];
      chk("ref", rv[15:0], ref_v);
    end
    // low level only after leaving the current loop, so no fault yet
    wreg(`REG_OFFSET, 32'hFFF0);
    wreg(`REG_CTRL, cw(2, 0, 0));
    code <= 12'd8;
    pause(4);
    chk("clamp", 16'h0000, ref_v);
    chk("fault", 16'h0000, 16'(lf));
    $display("scaling test done");
    code <= 12'd300;
    wreg(`REG_CTRL, cw(4, 0, 0));
    pause(4);
    chk("fault", 16'h0001, 16'(lf));
    chk("relay", 16'h0001, 16'(relay));
    wreg(`REG_PRESET, 32'h0123);
    wreg(`REG_CTRL, cw(10, 0, 0));
    pause(4);
    chk("alarm", 16'h0001, 16'(la));
    chk("ref", 16'h0123, ref_v);
    code <= 12'd900;
    pause(4);
    chk("alarm", 16'h0000, 16'(la));
    chk("ref", 16'd130, ref_v);
    // both snapshots fill with the live level before the loss
    wreg(`REG_CTRL, cw(8, 0, 0));
    pause(40);
    code <= 12'd300;
    pause(4);
    chk("alarm", 16'h0001, 16'(la));
    chk("held", 16'd130, ref_v);
    code <= 12'd900;
    pause(4);
    wreg(`REG_STATUS, 32'h1);
    pause(1);
    chk("fault", 16'h0000, 16'(lf));
    $display("loss test done");
    wreg(`REG_CTRL, cw(2, 0, 1));
    run <= 1'b1;
    pause(20);
    chk("volt", 16'h0000, 16'(volt));
    pause(5);
    chk("volt", 16'h0001, 16'(volt));
    chk("relay", 16'h0001, 16'(relay));
    run <= 1'b0;
    wreg(`REG_CTRL, cw(2, 0, 2));
    pause(3);
    chk("volt", 16'h0000, 16'(volt));
    run <= 1'b1;
    pause(4);
    chk("volt", 16'h0001, 16'(volt));
    // analog start and stop with every contact closed
    code <= 12'd100;
    wreg(`REG_CTRL, cw(12, 0, 2) | 32'h400);
    pause(4);
    chk("volt", 16'h0000, 16'(volt));
    code <= 12'd1100;
    pause(5);
    chk("volt", 16'h0001, 16'(volt));
    code <= 12'd100;
    pause(5);
    chk("volt", 16'h0000, 16'(volt));
    $display("start test done");
    @(posedge clk);
    fb.speed <= 16'sh0100;
    pause(60);
    chk("aout", 16'h0810, 16'(aout));
    @(posedge clk);
    fb.speed <= -16'sh0100;
    wreg(`REG_CTRL, cw(2, 2, 2));
    pause(60);
    chk("aout", 16'h0020, 16'(aout));
    // vector refresh is fast enough to show within a dozen cycles
    @(posedge clk);
    fb <= '{-16'sh0100, 16'sh0200, 16'sh0400};
    wreg(`REG_CTRL, cw(2, 3, 2) | 32'h200);
    pause(12);
    chk("aout", 16'h0040, 16'(aout));
    wreg(`REG_CTRL, cw(2, 3, 2));
    pause(60);
    chk("aout", 16'h0080, 16'(aout));
    $display("output test done");
    wrap_up();
  end
endmodule // analog_reference_io_conditioning_bench

// ==== aref_cond_defines.svh ====
// constants for the analog reference and terminal i/o conditioning block
// assumes a 40 MHz reference clock and a 12-bit converter on the input
`ifndef AREF_COND_DEFINES_SVH
`define AREF_COND_DEFINES_SVH

// ==========================================================================
// register offsets (byte addresses on the plain register port)
`define REG_CTRL        8'h00
`define REG_OFFSET      8'h04
`define REG_GAIN        8'h08
`define REG_PRESET      8'h0C
`define REG_START_THR   8'h10
`define REG_STOP_THR    8'h14
`define REG_STATUS      8'h18
`define REG_REF         8'h1C

// ==========================================================================
// field positions
`define CTRL_AIN_LSB    0
`define CTRL_AOUT_LSB   4
`define CTRL_RELAY_LSB  6
`define CTRL_VECTOR_BIT 9
`define CTRL_REMOTE_BIT 10
`define STAT_FAULT_BIT  0
`define STAT_ALARM_BIT  1
`define STAT_RELAY_BIT  2
`define STAT_VOLT_BIT   3
`define STAT_ARUN_BIT   4

// ==========================================================================
// reset values and highest accepted codes
`define RST_AIN_CFG     4'h2
`define RST_AOUT_SRC    2'h0
`define RST_RELAY_CFG   3'h0
`define RST_GAIN        16'h0100
`define RST_START_THR   16'h0800
`define RST_STOP_THR    16'h0400
`define AIN_CFG_MAX     4'hC
`define RELAY_CFG_MAX   3'h6

// ==========================================================================
// converter scaling: full code is 20 mA on the current input
`define AIN_FS_CODE     4095
`define AIN_4MA_CODE    ((`AIN_FS_CODE * 4) / 20)
`define AIN_2MA_CODE    ((`AIN_FS_CODE * 2) / 20)
`define AIN_BIP_MID     2048
`define REF_LIMIT       32767
`define AOUT_FULL       4095

// ==========================================================================
// timing: figures in microseconds, counts derived from the clock rate
`define CLK_HZ          40000000
`define T_UPD_VHZ_US    500000
`define T_UPD_VEC_US    5000
`define T_START_DLY_US  500000
`define T_SNAP_US       1000000
`define US_TO_CYC(t)    ((`CLK_HZ / 1000000) * (t))
`define UPD_VHZ_CYC     `US_TO_CYC(`T_UPD_VHZ_US)
`define UPD_VEC_CYC     `US_TO_CYC(`T_UPD_VEC_US)
`define START_DLY_CYC   `US_TO_CYC(`T_START_DLY_US)
`define SNAP_CYC        `US_TO_CYC(`T_SNAP_US)
`define HIST_DEPTH      5

`endif

// ==== aref_cond_pkg.sv ====
// types shared by the analog reference conditioning block
// assumes nothing beyond a SystemVerilog compiler
package aref_cond_pkg;

  // terminal strip contacts, high when closed
  typedef struct packed {
    logic start_closed;
    logic stop_closed;
    logic func_loss_closed;
  } term_in_t;

  // drive signals offered to the analog output
  typedef struct packed {
    logic signed [15:0] speed;
    logic signed [15:0] torque;
    logic signed [15:0] current;
  } drive_fb_t;

  // control word held in the control register
  typedef struct packed {
    logic       remote_terminal_source;
    logic       vector_mode;
    logic [2:0] relay_cfg;
    logic [1:0] aout_src;
    logic [3:0] ain_cfg;
  } ctrl_t;

  // start delay sequencer
  typedef enum {DLY_IDLE, DLY_WAIT, DLY_ON} start_state_t;

  // analog start/stop decision
  typedef enum {ARUN_STOP, ARUN_RUN} arun_state_t;

endpackage

// ==== aref_far_side.sv ====
// far-side model: input converter and terminal strip contacts
// assumes the bench sets the wanted level and the run request
module aref_far_side
  import aref_cond_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic [11:0] code_i,
  input  wire logic        run_i,
  output logic      [11:0] adc_o,
  output term_in_t         term_o
);
  // ====
  // converter lags the wanted level by one sample, as a real one does;
  // one driver only, the first clock edge gives both a defined level
  always @(posedge ref_clk_i) begin
    adc_o  <= code_i;
    term_o <= {3{run_i}};
  end
endmodule // aref_far_side
